/* File: src/fee_engine.sv */
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// How it works
// - erased bits read one; programs only clear bits, rewrites need erase
// - address and data go to holding registers, then one command strobe
// - every program stores one whole 64-bit double word atomically
// - lower and upper halves are programmed together at one address
// - no word, half-word or byte program command exists on the path
// - each access carries 64 data bits plus one 8-bit check byte
// - pages hold 2 kB data plus 256 bytes of check bytes
// - programs set data and check; a second program gives check error
// - no flash command until initialisation done; reads return 64 bits
// - byte read translates, fetches, shifts and masks; range error
// - whole erase clears all region pages, refused when controller busy
// - first operand is bits 31:0, second operand the upper 32 bits
// - translated read address outside region returns an error
// - moving to a new page copies data first, then erases old page
// - page erase outside the region is refused with an error
// - rewrite copies the sector, byte substituted, into the next sector
// - writing 0xFF over stored 0xFF issues no program at all
// - size 8 B to 2040 B with two pages, word length 8 to 64 bits
// - write reads the location; only if erased it programs in place
// - last double word of each sector holds the sector tag
module fee_engine
  import fee_pkg::*;
(
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  // configuration
  input  wire logic [11:0]  cfgSize,
  input  wire logic [6:0]   cfgWordLen,
  // request
  input  wire logic         reqValid,
  input  wire fee_op_t      reqOp,
  input  wire logic [11:0]  reqAddr,
  input  wire logic [7:0]   reqData,
  // answer
  output logic              busy,
  output logic              done,
  output var fee_err_t      errCode,
  output logic [7:0]        rdData,
  // flash controller
  input  wire logic         flReady,
  input  wire logic         flBusy,
  input  wire logic         flDone,
  input  wire logic         flFail,
  input  wire logic [71:0]  flRdData,
  output logic              flGo,
  output var fee_fcmd_t     flCmd,
  output logic [18:0]       flAddr,
  output logic [31:0]       flKeyLo,
  output logic [31:0]       flKeyHi,
  output logic [7:0]        flKeyChk
);

  typedef enum {
    S_SCAN, S_SCAN_W, S_IDLE, S_RD_W, S_WR_W, S_PLACE_W, S_TAG, S_TAG_W,
    S_MV_RD, S_MV_RD_W, S_MV_PG_W, S_ER_OLD_W, S_ER, S_ER_W
  } fee_state_t;

  fee_state_t  state, next_state;
  logic        next_busy, next_done;
  fee_err_t    next_errCode;
  logic [7:0]  next_rdData;
  // sector bookkeeping
  logic [9:0]  curBase, next_curBase, newBase, next_newBase;
  logic [9:0]  scanBase, next_scanBase;
  logic [15:0] curSeq, next_curSeq, curCount, next_curCount;
  logic        tagSet, next_tagSet, moving, next_moving;
  // request capture
  logic [2:0]  lane, next_lane;
  logic [8:0]  tgt, next_tgt, idx, next_idx;
  logic [7:0]  wrByte, next_wrByte;
  logic [1:0]  erPage, next_erPage;
  // operation towards the flash port
  logic        opStart, next_opStart, opDone;
  fee_fcmd_t   opKind, next_opKind;
  logic [9:0]  opDw, next_opDw;
  logic [31:0] opLo, next_opLo, opHi, next_opHi;
  fee_err_t    opErr;
  logic [63:0] opRdData;
  // geometry derived from the configured size
  logic [9:0]  sizeDw, dwPerSec;
  logic        cfgOk;

  ////////////////////////////////////////////////////////////////////////////
  // byte lane helpers, used by read, in-place write and sector move
  function automatic logic [7:0] fee_get_byte(input logic [63:0] dw,
                                              input logic [2:0]  ln);
    return dw[{ln, 3'h0} +: 8];
  endfunction : fee_get_byte

  function automatic logic [63:0] fee_put_byte(input logic [63:0] dw,
                                               input logic [2:0]  ln,
                                               input logic [7:0]  b);
    logic [63:0] r;
    r = dw;
    r[{ln, 3'h0} +: 8] = b;
    return r;
  endfunction : fee_put_byte

  // next sector start; a sector never straddles a page, region wraps
  function automatic logic [9:0] fee_next_sector(input logic [9:0] base,
                                                 input logic [9:0] span);
    logic [9:0] nb;
    logic [9:0] last;
    nb   = base + span;
    last = nb + span - 10'h001;
    if (last[9:8] != nb[9:8]) begin
      nb = {nb[9:8] + 2'h1, 8'h00};
    end
    if (nb[9:8] >= NUM_PAGES) begin
      nb = 10'h000;
    end
    return nb;
  endfunction : fee_next_sector

  ////////////////////////////////////////////////////////////////////////////
  // geometry: data double words plus one tag word per sector
  assign sizeDw   = {1'b0, cfgSize[11:3]};
  assign dwPerSec = sizeDw + 10'h001;
  // word length only validated; storage is byte granular either way
  assign cfgOk    = cfgSize >= EMU_MIN_SIZE && cfgSize <= EMU_MAX_SIZE &&
                    cfgSize[2:0] == 3'h0 &&
                    (cfgWordLen == 7'h08 || cfgWordLen == 7'h10 ||
                     cfgWordLen == 7'h20 || cfgWordLen == 7'h40);

  ////////////////////////////////////////////////////////////////////////////
  // main sequencer
  always_comb begin
    logic [63:0] val;
    val           = ERASED_DW;
    next_state    = state;
    next_busy     = busy;
    next_done     = 1'b0;
    next_errCode  = errCode;
    next_rdData   = rdData;
    next_curBase  = curBase;
    next_newBase  = newBase;
    next_scanBase = scanBase;
    next_curSeq   = curSeq;
    next_curCount = curCount;
    next_tagSet   = tagSet;
    next_moving   = moving;
    next_lane     = lane;
    next_tgt      = tgt;
    next_idx      = idx;
    next_wrByte   = wrByte;
    next_erPage   = erPage;
    next_opStart  = 1'b0;
    next_opKind   = opKind;
    next_opDw     = opDw;
    next_opLo     = opLo;
    next_opHi     = opHi;
    case (state)
      // walk all sector tags once after reset to find the live sector
      S_SCAN: begin
        next_opStart = 1'b1;
        next_opKind  = FEE_F_READ;
        next_opDw    = scanBase + sizeDw;
        next_state   = S_SCAN_W;
      end
      S_SCAN_W: begin
        if (opDone) begin
          if (opErr == FEE_OK && opRdData[63:32] == TAG_MARK &&
              (!tagSet || opRdData[31:16] >= curSeq)) begin
            next_curBase  = scanBase;
            next_curSeq   = opRdData[31:16];
            next_curCount = opRdData[15:0];
            next_tagSet   = 1'b1;
          end
          next_scanBase = fee_next_sector(scanBase, dwPerSec);
          if (next_scanBase == 10'h000) begin
            next_busy  = 1'b0;
            next_state = S_IDLE;
          end else begin
            next_state = S_SCAN;
          end
        end
      end
      S_IDLE: begin
        if (reqValid) begin
          next_busy   = 1'b1;
          next_lane   = reqAddr[2:0];
          next_tgt    = reqAddr[11:3];
          next_wrByte = reqData;
          if (reqOp == FEE_OP_ERASE) begin
            if (flBusy) begin
              next_busy  = 1'b0;
              next_done  = 1'b1;
              next_errCode = FEE_ERR_BUSY;
            end else begin
              next_erPage = 2'h0;
              next_state  = S_ER;
            end
          end else if (!cfgOk || reqAddr >= cfgSize) begin
            next_busy = 1'b0;
            next_done = 1'b1;
            next_errCode = FEE_ERR_RANGE;
          end else begin
            next_opStart = 1'b1;
            next_opKind  = FEE_F_READ;
            next_opDw    = curBase + {1'b0, reqAddr[11:3]};
            next_state   = (reqOp == FEE_OP_READ) ? S_RD_W : S_WR_W;
          end
        end
      end
      S_RD_W: begin
        if (opDone) begin
          if (opErr == FEE_OK) begin
            next_rdData = fee_get_byte(opRdData, lane);
          end
          next_busy  = 1'b0;
          next_done  = 1'b1;
          next_errCode = opErr;
          next_state = S_IDLE;
        end
      end
      S_WR_W: begin
        if (opDone) begin
          if (opErr != FEE_OK) begin
            next_busy  = 1'b0;
            next_done  = 1'b1;
            next_errCode = opErr;
            next_state = S_IDLE;
          end else if (fee_get_byte(opRdData, lane) == ERASED_BYTE &&
                       wrByte == ERASED_BYTE) begin
            next_busy  = 1'b0;
            next_done  = 1'b1;
            next_errCode = FEE_OK;
            next_state = S_IDLE;
          end else if (opRdData == ERASED_DW) begin
            // never programmed: one program in place is legal
            val          = fee_put_byte(ERASED_DW, lane, wrByte);
            next_opStart = 1'b1;
            next_opKind  = FEE_F_PROG;
            next_opLo    = val[31:0];
            next_opHi    = val[63:32];
            next_curCount = curCount + 16'h0001;
            next_state   = S_PLACE_W;
          end else begin
            // any other rewrite would program an already programmed double word again
            next_newBase = fee_next_sector(curBase, dwPerSec);
            next_idx     = 9'h000;
            next_moving  = 1'b1;
            next_state   = S_MV_RD;
          end
        end
      end
      S_PLACE_W: begin
        if (opDone) begin
          if (opErr == FEE_OK && !tagSet) begin
            next_newBase = curBase;
            next_state   = S_TAG;
          end else begin
            next_busy  = 1'b0;
            next_done  = 1'b1;
            next_errCode = opErr;
            next_state = S_IDLE;
          end
        end
      end
      // tag is programmed once per sector so it is never rewritten
      S_TAG: begin
        next_opStart = 1'b1;
        next_opKind  = FEE_F_PROG;
        next_opDw    = newBase + sizeDw;
        next_opLo    = {moving ? curSeq + 16'h0001 : curSeq,
                        moving ? curCount + 16'h0001 : curCount};
        next_opHi    = TAG_MARK;
        next_state   = S_TAG_W;
      end
      S_TAG_W: begin
        if (opDone) begin
          if (opErr == FEE_OK) begin
            next_tagSet = 1'b1;
          end
          if (opErr == FEE_OK && moving) begin
            next_curBase  = newBase;
            next_curSeq   = curSeq + 16'h0001;
            next_curCount = curCount + 16'h0001;
            next_moving   = 1'b0;
          end
          if (opErr == FEE_OK && moving && newBase[9:8] != curBase[9:8]) begin
            // data is safe in the new page, only now drop the old one
            next_opStart = 1'b1;
            next_opKind  = FEE_F_ERASE;
            next_opDw    = {curBase[9:8], 8'h00};
            next_state   = S_ER_OLD_W;
          end else begin
            next_moving = 1'b0;
            next_busy   = 1'b0;
            next_done   = 1'b1;
            next_errCode = opErr;
            next_state  = S_IDLE;
          end
        end
      end
      S_MV_RD: begin
        if ({1'b0, idx} == sizeDw) begin
          next_state = S_TAG;
        end else begin
          next_opStart = 1'b1;
          next_opKind  = FEE_F_READ;
          next_opDw    = curBase + {1'b0, idx};
          next_state   = S_MV_RD_W;
        end
      end
      S_MV_RD_W: begin
        if (opDone) begin
          val = (idx == tgt) ? fee_put_byte(opRdData, lane, wrByte) : opRdData;
          if (opErr != FEE_OK) begin
            next_moving = 1'b0;
            next_busy   = 1'b0;
            next_done   = 1'b1;
            next_errCode = opErr;
            next_state  = S_IDLE;
          end else if (val == ERASED_DW) begin
            // erased words need no program in the fresh sector
            next_idx   = idx + 9'h001;
            next_state = S_MV_RD;
          end else begin
            next_opStart = 1'b1;
            next_opKind  = FEE_F_PROG;
            next_opDw    = newBase + {1'b0, idx};
            next_opLo    = val[31:0];
            next_opHi    = val[63:32];
            next_state   = S_MV_PG_W;
          end
        end
      end
      S_MV_PG_W: begin
        if (opDone) begin
          if (opErr != FEE_OK) begin
            next_moving = 1'b0;
            next_busy   = 1'b0;
            next_done   = 1'b1;
            next_errCode = opErr;
            next_state  = S_IDLE;
          end else begin
            next_idx   = idx + 9'h001;
            next_state = S_MV_RD;
          end
        end
      end
      S_ER_OLD_W: begin
        if (opDone) begin
          next_busy  = 1'b0;
          next_done  = 1'b1;
          next_errCode = opErr;
          next_state = S_IDLE;
        end
      end
      // whole-space erase, one page command per region page
      S_ER: begin
        if (erPage == NUM_PAGES) begin
          next_curBase  = 10'h000;
          next_curSeq   = 16'h0000;
          next_curCount = 16'h0000;
          next_tagSet   = 1'b0;
          next_busy     = 1'b0;
          next_done     = 1'b1;
          next_errCode  = FEE_OK;
          next_state    = S_IDLE;
        end else begin
          next_opStart = 1'b1;
          next_opKind  = FEE_F_ERASE;
          next_opDw    = {erPage, 8'h00};
          next_state   = S_ER_W;
        end
      end
      S_ER_W: begin
        if (opDone) begin
          if (opErr != FEE_OK) begin
            next_busy  = 1'b0;
            next_done  = 1'b1;
            next_errCode = opErr;
            next_state = S_IDLE;
          end else begin
            next_erPage = erPage + 2'h1;
            next_state  = S_ER;
          end
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state    <= S_SCAN;
      busy     <= 1'b1;
      done     <= 1'b0;
      errCode  <= FEE_OK;
      rdData   <= 8'h00;
      curBase  <= 10'h000;
      newBase  <= 10'h000;
      scanBase <= 10'h000;
      curSeq   <= 16'h0000;
      curCount <= 16'h0000;
      tagSet   <= 1'b0;
      moving   <= 1'b0;
      lane     <= 3'h0;
      tgt      <= 9'h000;
      idx      <= 9'h000;
      wrByte   <= 8'h00;
      erPage   <= 2'h0;
      opStart  <= 1'b0;
      opKind   <= FEE_F_READ;
      opDw     <= 10'h000;
      opLo     <= 32'h0000_0000;
      opHi     <= 32'h0000_0000;
    end else begin
      state    <= next_state;
      busy     <= next_busy;
      done     <= next_done;
      errCode  <= next_errCode;
      rdData   <= next_rdData;
      curBase  <= next_curBase;
      newBase  <= next_newBase;
      scanBase <= next_scanBase;
      curSeq   <= next_curSeq;
      curCount <= next_curCount;
      tagSet   <= next_tagSet;
      moving   <= next_moving;
      lane     <= next_lane;
      tgt      <= next_tgt;
      idx      <= next_idx;
      wrByte   <= next_wrByte;
      erPage   <= next_erPage;
      opStart  <= next_opStart;
      opKind   <= next_opKind;
      opDw     <= next_opDw;
      opLo     <= next_opLo;
      opHi     <= next_opHi;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // keyhole port to the flash controller
  fee_flash_port u_port (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .opStart  (opStart),
    .opKind   (opKind),
    .opDw     (opDw),
    .opLo     (opLo),
    .opHi     (opHi),
    .opDone   (opDone),
    .opErr    (opErr),
    .opRdData (opRdData),
    .flReady  (flReady),
    .flBusy   (flBusy),
    .flDone   (flDone),
    .flFail   (flFail),
    .flRdData (flRdData),
    .flGo     (flGo),
    .flCmd    (flCmd),
    .flAddr   (flAddr),
    .flKeyLo  (flKeyLo),
    .flKeyHi  (flKeyHi),
    .flKeyChk (flKeyChk)
  );

endmodule : fee_engine

`default_nettype wire

/* File: src/fee_pkg.sv */
package fee_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // flash geometry
  localparam int          DW_BYTES         = 8;
  localparam int          PAGE_BYTES       = 2048;
  localparam int          PAGE_CHECK_BYTES = 256;
  localparam int          DW_PER_PAGE      = PAGE_BYTES / DW_BYTES;
  localparam logic [1:0]  NUM_PAGES        = 2'h2;
  localparam logic [9:0]  REGION_DW        = 10'h200;
  // first flash page of the emulation region, arbitrary placement
  localparam logic [7:0]  REGION_BASE_PAGE = 8'hF0;

  ////////////////////////////////////////////////////////////////////////////
  // emulated space limits and fixed values
  localparam logic [11:0] EMU_MIN_SIZE     = 12'h008;
  localparam logic [11:0] EMU_MAX_SIZE     = 12'h7F8;
  localparam logic [7:0]  ERASED_BYTE      = 8'hFF;
  localparam logic [63:0] ERASED_DW        = 64'hFFFF_FFFF_FFFF_FFFF;
  // sector tag marker in the upper tag half, arbitrary value
  localparam logic [31:0] TAG_MARK         = 32'hA5C3_0F1E;

  ////////////////////////////////////////////////////////////////////////////
  // request kinds, flash commands, answer codes
  typedef enum logic [1:0] {
    FEE_OP_READ,
    FEE_OP_WRITE,
    FEE_OP_ERASE
  } fee_op_t;

  typedef enum logic [1:0] {
    FEE_F_READ,
    FEE_F_PROG,
    FEE_F_ERASE
  } fee_fcmd_t;

  typedef enum logic [1:0] {
    FEE_OK,
    FEE_ERR_RANGE,
    FEE_ERR_BUSY,
    FEE_ERR_CHECK
  } fee_err_t;

  // check byte: inverted parity per byte, so an erased word checks as 0xFF
  function automatic logic [7:0] fee_check(input logic [63:0] dw);
    logic [7:0] chk;
    chk = 8'h00;
    for (int i = 0; i < 8; i++) begin
      chk[i] = ~^dw[i*8 +: 8];
    end
    return chk;
  endfunction : fee_check

endpackage : fee_pkg

/* File: src/fee_flash_port.sv */
`timescale 1ns/10ps
`default_nettype none

module fee_flash_port
  import fee_pkg::*;
(
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  // operation from the engine
  input  wire logic         opStart,
  input  wire fee_fcmd_t    opKind,
  input  wire logic [9:0]   opDw,
  input  wire logic [31:0]  opLo,
  input  wire logic [31:0]  opHi,
  output logic              opDone,
  output var fee_err_t      opErr,
  output logic [63:0]       opRdData,
  // flash controller
  input  wire logic         flReady,
  input  wire logic         flBusy,
  input  wire logic         flDone,
  input  wire logic         flFail,
  input  wire logic [71:0]  flRdData,
  output logic              flGo,
  output var fee_fcmd_t     flCmd,
  output logic [18:0]       flAddr,
  output logic [31:0]       flKeyLo,
  output logic [31:0]       flKeyHi,
  output logic [7:0]        flKeyChk
);

  typedef enum {P_IDLE, P_ARM, P_WAIT} fee_port_t;

  fee_port_t   state, next_state;
  logic        next_opDone, next_flGo;
  fee_err_t    next_opErr;
  fee_fcmd_t   next_flCmd;
  logic [63:0] next_opRdData;
  logic [18:0] next_flAddr;
  logic [31:0] next_flKeyLo, next_flKeyHi;
  logic [7:0]  next_flKeyChk, pageAbs;

  ////////////////////////////////////////////////////////////////////////////
  // keyhole sequencer: load holding registers, then one command strobe
  always_comb begin
    next_state    = state;
    next_opDone   = 1'b0;
    next_flGo     = 1'b0;
    next_opErr    = opErr;
    next_opRdData = opRdData;
    next_flCmd    = flCmd;
    next_flAddr   = flAddr;
    next_flKeyLo  = flKeyLo;
    next_flKeyHi  = flKeyHi;
    next_flKeyChk = flKeyChk;
    pageAbs       = REGION_BASE_PAGE + {6'h00, opDw[9:8]};
    case (state)
      P_IDLE: begin
        if (opStart) begin
          if (opDw >= REGION_DW) begin
            // outside the region: answer at once, flash untouched
            next_opDone = 1'b1;
            next_opErr  = FEE_ERR_RANGE;
          end else begin
            next_flCmd    = opKind;
            next_flAddr   = {pageAbs, opDw[7:0], 3'h0};
            next_flKeyLo  = opLo;
            next_flKeyHi  = opHi;
            next_flKeyChk = fee_check({opHi, opLo});
            next_state    = P_ARM;
          end
        end
      end
      P_ARM: begin
        // no command until the array finished its own start-up
        if (flReady && !flBusy) begin
          next_flGo  = 1'b1;
          next_state = P_WAIT;
        end
      end
      P_WAIT: begin
        if (flDone) begin
          next_opDone   = 1'b1;
          next_opRdData = flRdData[63:0];
          next_state    = P_IDLE;
          if (flFail) begin
            next_opErr = FEE_ERR_CHECK;
          end else if (flCmd == FEE_F_READ &&
                       flRdData[71:64] != fee_check(flRdData[63:0])) begin
            next_opErr = FEE_ERR_CHECK;
          end else begin
            next_opErr = FEE_OK;
          end
        end
      end
      default: next_state = P_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state    <= P_IDLE;
      opDone   <= 1'b0;
      opErr    <= FEE_OK;
      opRdData <= 64'h0000_0000_0000_0000;
      flGo     <= 1'b0;
      flCmd    <= FEE_F_READ;
      flAddr   <= 19'h0_0000;
      flKeyLo  <= 32'h0000_0000;
      flKeyHi  <= 32'h0000_0000;
      flKeyChk <= 8'h00;
    end else begin
      state    <= next_state;
      opDone   <= next_opDone;
      opErr    <= next_opErr;
      opRdData <= next_opRdData;
      flGo     <= next_flGo;
      flCmd    <= next_flCmd;
      flAddr   <= next_flAddr;
      flKeyLo  <= next_flKeyLo;
      flKeyHi  <= next_flKeyHi;
      flKeyChk <= next_flKeyChk;
    end
  end

endmodule : fee_flash_port

`default_nettype wire

/* File: tb/fee_flash_model.sv */
`timescale 1ns/10ps
`default_nettype none
module fee_flash_model
  import fee_pkg::*;
(
  // engine side
  input  wire logic        core_clk, arst_n, flGo, stall,
  input  wire fee_fcmd_t   flCmd,
  input  wire logic [18:0] flAddr,
  input  wire logic [31:0] flKeyLo, flKeyHi,
  input  wire logic [7:0]  flKeyChk,
  // controller answers
  output logic             flReady, flBusy, flDone, flFail,
  output logic [71:0]      flRdData
);
  logic [71:0] mem [512];
  logic        act;
  // region starts erased; flash keeps it across reset
  initial for (int i = 0; i < 512; i++) mem[i] = '1;
  assign flBusy = act | stall;
  // one command at a time, answered two cycles after its strobe
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flReady <= 1'b0;
      act     <= 1'b0;
      flDone  <= 1'b0;
      flFail  <= 1'b0;
    end else begin
      flReady  <= 1'b1;
      act      <= flGo;
      flDone   <= act;
      flFail   <= 1'b0;
      flRdData <= ~flRdData; // bus released, old data must not linger
      if (act && flCmd == FEE_F_READ)
        flRdData <= mem[flAddr[11:3]];
      if (act && flCmd == FEE_F_PROG) begin
        flFail <= mem[flAddr[11:3]][63:0] != ERASED_DW;
        mem[flAddr[11:3]] <= mem[flAddr[11:3]] &
          {flKeyChk, flKeyHi, flKeyLo};
      end
      if (act && flCmd == FEE_F_ERASE)
        for (int i = 0; i < 256; i++)
          mem[{flAddr[11], i[7:0]}] <= '1;
    end
  end
endmodule : fee_flash_model
`default_nettype wire

/* File: tb/fee_engine_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module fee_engine_chk
  import fee_pkg::*;
(
  input  wire logic        core_clk, arst_n, reqValid, busy, done,
  input  wire logic        flReady, flBusy, flGo,
  input  wire fee_op_t     reqOp,
  input  wire logic [11:0] reqAddr, cfgSize,
  input  wire fee_err_t    errCode,
  input  wire fee_fcmd_t   flCmd,
  input  wire logic [18:0] flAddr,
  input  wire logic [31:0] flKeyLo, flKeyHi,
  input  wire logic [7:0]  flKeyChk
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  function automatic logic [7:0] par(input logic [63:0] v);
    for (int i = 0; i < 8; i++) par[i] = ~^v[i*8 +: 8];
  endfunction : par
  wire logic take = reqValid && !busy;
  a_take_busy: assert property (take |=> busy || done)
    else $error("busy missing");
  a_done_pulse: assert property (done && !reqValid |=> !done)
    else $error("done too long");
  a_done_free: assert property (done |-> !busy)
    else $error("busy with done");
  a_go_ready: assert property (flGo |-> $past(flReady && !flBusy))
    else $error("strobe too early");
  a_go_stable: assert property (flGo |-> $stable(flAddr) &&
    $stable(flCmd) && $stable({flKeyHi, flKeyLo})) else $error("unstable");
  a_key_check: assert property (flGo && flCmd == FEE_F_PROG |->
    flKeyChk == par({flKeyHi, flKeyLo})) else $error("bad check");
  a_go_region: assert property (flGo |-> flAddr[2:0] == 3'h0 &&
    flAddr[18:12] == REGION_BASE_PAGE[7:1]) else $error("bad address");
  a_range_err: assert property (take && reqOp != FEE_OP_ERASE &&
    reqAddr >= cfgSize |-> ##[1:2] done && errCode == FEE_ERR_RANGE)
    else $error("no range error");
  a_erase_busy: assert property (take && reqOp == FEE_OP_ERASE &&
    flBusy |-> ##[1:2] done && errCode == FEE_ERR_BUSY)
    else $error("no busy error");
endmodule : fee_engine_chk
bind fee_engine fee_engine_chk i_chk (.core_clk, .arst_n, .reqValid,
  .busy, .done, .flReady, .flBusy, .flGo, .reqOp, .reqAddr, .cfgSize,
  .errCode, .flCmd, .flAddr, .flKeyLo, .flKeyHi, .flKeyChk);
`default_nettype wire

/* File: tb/fee_engine_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module fee_engine_tb_top
  import fee_pkg::*;
;
  logic        core_clk = 0, arst_n = 0, reqValid = 0, stall = 0;
  fee_op_t     reqOp = FEE_OP_READ;
  logic [11:0] reqAddr = '0, cfgSize = 12'h010;
  logic [7:0]  reqData = '0, rdData, flKeyChk;
  logic        busy, done, flReady, flBusy, flDone, flFail, flGo;
  fee_err_t    errCode;
  fee_fcmd_t   flCmd;
  logic [71:0] flRdData;
  logic [18:0] flAddr;
  logic [31:0] flKeyLo, flKeyHi;
  int          n_fail = 0, comparisons = 0, nProg = 0, n0;
  // 16 byte space: two data dwords plus tag per sector
  fee_engine i_fee_engine (.core_clk, .arst_n, .cfgSize,
    .cfgWordLen(7'h08), .reqValid, .reqOp, .reqAddr, .reqData, .busy,
    .done, .errCode, .rdData, .flReady, .flBusy, .flDone, .flFail,
    .flRdData, .flGo, .flCmd, .flAddr, .flKeyLo, .flKeyHi, .flKeyChk);
  fee_flash_model i_fee_flash_model (.core_clk, .arst_n, .flGo, .stall,
    .flCmd, .flAddr, .flKeyLo, .flKeyHi, .flKeyChk, .flReady, .flBusy,
    .flDone, .flFail, .flRdData);
  initial forever #20 core_clk = ~core_clk;
  always @(negedge core_clk) if (flGo === 1'b1 && flCmd == FEE_F_PROG) nProg++;
  ////////////////////////////////////////////////////////////////////////////
  // one request: wait idle, strobe once, wait done, judge the answer
  task automatic req(input fee_op_t op, input logic [11:0] a,
      input logic [7:0] d, input fee_err_t e, input logic [7:0] r);
    @(negedge core_clk);
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge core_clk);
    reqValid = 1'b1;
    reqOp = op;
    reqAddr = a;
    reqData = d;
    @(negedge core_clk);
    reqValid = 1'b0;
    for (int i = 0; i < 3000 && done !== 1'b1; i++) @(negedge core_clk);
    `CHK(done, 1'b1)
    `CHK(errCode, e)
    if (op == FEE_OP_READ && e == FEE_OK) `CHK(rdData, r)
  endtask : req
  task automatic tally_and_finish;
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge core_clk);
    arst_n = 1'b1;
    req(FEE_OP_READ, 12'h00F, 8'h00, FEE_OK, 8'hFF);
    req(FEE_OP_READ, 12'h010, 8'h00, FEE_ERR_RANGE, 8'h00);
    req(FEE_OP_WRITE, 12'h005, 8'h5A, FEE_OK, 8'h00);
    req(FEE_OP_READ, 12'h005, 8'h00, FEE_OK, 8'h5A);
    req(FEE_OP_READ, 12'h004, 8'h00, FEE_OK, 8'hFF);
    // enough rewrites to walk off the first page and erase it
    for (int k = 0; k < 90; k++)
      req(FEE_OP_WRITE, 12'h005, k[7:0], FEE_OK, 8'h00);
    req(FEE_OP_WRITE, 12'h00C, 8'h33, FEE_OK, 8'h00);
    req(FEE_OP_READ, 12'h005, 8'h00, FEE_OK, 8'h59);
    req(FEE_OP_READ, 12'h00C, 8'h00, FEE_OK, 8'h33);
    n0 = nProg;
    req(FEE_OP_WRITE, 12'h00E, 8'hFF, FEE_OK, 8'h00);
    `CHK(nProg - n0, 0)
    stall = 1'b1;
    req(FEE_OP_ERASE, 12'h000, 8'h00, FEE_ERR_BUSY, 8'h00);
    stall = 1'b0;
    req(FEE_OP_ERASE, 12'h000, 8'h00, FEE_OK, 8'h00);
    req(FEE_OP_READ, 12'h00C, 8'h00, FEE_OK, 8'hFF);
    cfgSize = 12'h7F9;
    req(FEE_OP_READ, 12'h000, 8'h00, FEE_ERR_RANGE, 8'h00);
    tally_and_finish;
  end
  // watchdog well beyond the expected few thousand cycles
  initial begin
    #2000000;
    n_fail++;
    tally_and_finish;
  end
endmodule : fee_engine_tb_top
`default_nettype wire
